// ==== rtl/t8sp_pkg.sv ====
package t8sp_pkg;
   // register byte offsets on the bus
   localparam logic [7:0] OPT_OFFS     = 8'h00;
   localparam logic [7:0] CNT_OFFS     = 8'h04;
   localparam logic [7:0] ICTL_OFFS    = 8'h08;
   localparam logic [7:0] STAT_OFFS    = 8'h0C;
   localparam logic [7:0] CLR_OFFS     = 8'h10;
   localparam logic [7:0] IEN_OFFS     = 8'h14;
   localparam logic [7:0] SYS_OFFS     = 8'h18;
   // option register layout
   localparam int         CSS_BIT      = 5;
   localparam int         SES_BIT      = 4;
   localparam int         PSA_BIT      = 3;
   localparam int         RATE_LSB     = 0;
   localparam int         RATE_W       = 3;
   localparam logic [7:0] OPT_RESET    = 8'hff;
   localparam logic [7:0] CNT_RESET    = 8'h00;
   localparam logic [7:0] ICTL_RESET   = 8'h00;
   // interrupt control layout
   localparam int         OVIE_BIT     = 5;
   localparam int         OVF_BIT      = 2;
   // status / enable / clear layout
   localparam int         EV_OVF       = 0;
   localparam int         EV_W         = 1;
   // system control register: sleep and clear-watchdog strobe
   localparam int         SLEEP_BIT    = 0;
   localparam int         CLEAR_WATCHDOG_INSTR_BIT   = 1;
   // instruction cycle = 4 system clocks (q1..q4)
   localparam int         QPH_W        = 2;
   localparam logic [1:0] Q2_PHASE     = 2'h1;
   localparam logic [1:0] Q4_PHASE     = 2'h3;
   localparam logic [1:0] INHIBIT_CYC  = 2'h2;
   localparam logic [1:0] HTRANS_NSEQ  = 2'h2;
   localparam logic [1:0] HSIZE_WORD   = 2'h2;
endpackage : t8sp_pkg

// ==== rtl/t8sp_timer.sv ====
`timescale 1ns/100ps
module t8sp_timer
   import t8sp_pkg::*;
#(
   parameter int PRE_W = 8
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        counter_input_pin,
   output logic             timer_irq,
   output logic             watchdog_tick,
   output logic             watchdog_clear
);
   // refuse sizes that the tap decoding and the single event bit cannot serve
   if (PRE_W != 8) begin : g_pre_w_check
      $error("prescaler must be 8 bits");
   end
   if (RATE_W != 3) begin : g_rate_w_check
      $error("rate field must be 3 bits");
   end
   if (EV_W != 1) begin : g_ev_w_check
      $error("one interrupt event expected");
   end

   logic [7:0]        opt_reg;
   logic [7:0]        cnt_reg;
   logic [7:0]        ictl_reg;
   logic [EV_W-1:0]   ien_reg;
   logic              sleep_reg;
   logic [PRE_W-1:0]  pre_reg;
   logic [QPH_W-1:0]  qph_reg;
   logic [1:0]        inhib_reg;
   logic              pin_s1_reg;
   logic              pin_s2_reg;
   logic              pin_q_reg;
   logic              pin_qd_reg;
   logic              ap_wr_reg;
   logic [7:0]        ap_addr_reg;
   logic              ap_valid_reg;

   logic              cyc_end;
   logic              src_event;
   logic              pre_timer;
   logic              pre_step;
   logic              tap;
   logic              tick;
   logic              cnt_step;
   logic              ovf_event;
   logic              irq_req;
   logic              cnt_wr;
   logic              opt_wr;
   logic              ictl_wr;
   logic              clr_wr;
   logic              wdt_clr;
   logic [7:0]        wsel;
   logic [RATE_W-1:0] rate;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] offs);
      return a == offs;
   endfunction

   // an address phase that this slave takes at the coming edge
   function automatic logic ahb_take(input logic rdy, input logic sel, input logic [1:0] trn);
      return rdy && sel && trn == HTRANS_NSEQ;
   endfunction

   // ones in the lowest r bits of the prescaler; r may reach the full width
   function automatic logic [PRE_W-1:0] low_mask(input logic [RATE_W:0] r);
      logic [PRE_W:0] m;
      m = ({{PRE_W{1'b0}}, 1'b1} << r) - {{PRE_W{1'b0}}, 1'b1};
      return m[PRE_W-1:0];
   endfunction

   // ---------------- ahb-lite slave, zero wait states ----------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_valid_reg <= 1'b0;
         ap_wr_reg    <= 1'b0;
         ap_addr_reg  <= 8'h00;
      end else if (hready) begin
         ap_valid_reg <= ahb_take(hready, hsel, htrans) && hsize[1:0] == HSIZE_WORD;
         ap_wr_reg    <= hwrite;
         ap_addr_reg  <= haddr[7:0];
      end
   end

   assign wsel    = (ap_valid_reg && ap_wr_reg) ? ap_addr_reg : 8'hff;
   assign cnt_wr  = hit(wsel, CNT_OFFS);
   assign opt_wr  = hit(wsel, OPT_OFFS);
   assign ictl_wr = hit(wsel, ICTL_OFFS);
   assign clr_wr  = hit(wsel, CLR_OFFS);
   assign wdt_clr = hit(wsel, SYS_OFFS) && hwdata[CLEAR_WATCHDOG_INSTR_BIT];

   // every transfer completes at once with an okay answer
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
      end else begin
         hreadyout <= 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hresp <= 1'b0;
      end else begin
         hresp <= 1'b0;
      end
   end

   // read data registered in the address phase; unmapped reads zero
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (ahb_take(hready, hsel, htrans) && !hwrite) begin
         unique case (haddr[7:0])
            OPT_OFFS:  hrdata <= {24'h00_0000, opt_reg};
            CNT_OFFS:  hrdata <= {24'h00_0000, cnt_reg};
            ICTL_OFFS: hrdata <= {24'h00_0000, ictl_reg};
            STAT_OFFS: hrdata <= {31'h0000_0000, ictl_reg[OVF_BIT]};
            IEN_OFFS:  hrdata <= {31'h0000_0000, ien_reg};
            SYS_OFFS:  hrdata <= {31'h0000_0000, sleep_reg};
            default:   hrdata <= 32'h0000_0000;
         endcase
      end
   end

   // ---------------- control registers ----------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         opt_reg <= OPT_RESET;
      end else if (opt_wr) begin
         opt_reg <= hwdata[7:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ien_reg <= '0;
      end else if (hit(wsel, IEN_OFFS)) begin
         ien_reg <= hwdata[EV_W-1:0];
      end
   end

   // sleep freezes counting only; the bus stays live so software can leave it
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sleep_reg <= 1'b0;
      end else if (hit(wsel, SYS_OFFS)) begin
         sleep_reg <= hwdata[SLEEP_BIT];
      end
   end

   // ---------------- instruction phase counter ----------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         qph_reg <= '0;
      end else begin
         qph_reg <= qph_reg + 2'h1;
      end
   end
   assign cyc_end = qph_reg == Q4_PHASE;

   // ---------------- external pin: sync then q2/q4 sample ----------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_s1_reg <= 1'b0;
         pin_s2_reg <= 1'b0;
      end else begin
         pin_s1_reg <= counter_input_pin;
         pin_s2_reg <= pin_s1_reg;
      end
   end

   // the raw level is kept and the edge is chosen later, so that flipping the
   // edge select bit never looks like a pin edge; reset matches the idle low pin
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_q_reg <= 1'b0;
      end else if (qph_reg == Q2_PHASE || qph_reg == Q4_PHASE) begin
         pin_q_reg <= pin_s2_reg;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_qd_reg <= 1'b0;
      end else begin
         pin_qd_reg <= pin_q_reg;
      end
   end

   // ---------------- source and shared prescaler ----------------
   assign pre_timer = !opt_reg[PSA_BIT];
   assign rate      = opt_reg[RATE_LSB +: RATE_W];

   // one event per counted edge; a level would advance on every clock while it lasts
   always_comb begin
      src_event = 1'b0;
      if (!opt_reg[CSS_BIT]) begin
         src_event = cyc_end;
      end else if (opt_reg[SES_BIT]) begin
         src_event = !pin_q_reg && pin_qd_reg;
      end else begin
         src_event = pin_q_reg && !pin_qd_reg;
      end
   end

   assign pre_step = !sleep_reg && (pre_timer ? src_event : cyc_end);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pre_reg <= '0;
      end else if ((cnt_wr && pre_timer) || (wdt_clr && !pre_timer)) begin
         pre_reg <= '0;
      end else if (pre_step) begin
         pre_reg <= pre_reg + 1'b1;
      end
   end

   // the selected bit rises when the step carries into it: lower bits all ones,
   // the bit itself clear; a rate change thus acts from the next event only
   assign tap = (pre_reg & low_mask({1'b0, rate} + {{RATE_W{1'b0}}, 1'b1})) ==
                low_mask({1'b0, rate});

   // with the prescaler given away the timer takes each source event directly
   always_comb begin
      if (pre_timer) begin
         tick = pre_step && tap;
      end else begin
         tick = src_event;
      end
   end
   assign cnt_step  = tick && !sleep_reg && inhib_reg == 2'h0;
   assign ovf_event = !cnt_wr && cnt_step && cnt_reg == 8'hff;

   // ---------------- watchdog link ----------------
   // code r divides the watchdog feed by 2**r, so code zero passes every cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         watchdog_tick <= 1'b0;
      end else begin
         watchdog_tick <= pre_step && !pre_timer &&
                          (pre_reg & low_mask({1'b0, rate})) == low_mask({1'b0, rate});
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         watchdog_clear <= 1'b0;
      end else begin
         watchdog_clear <= wdt_clr;
      end
   end

   // ---------------- count register ----------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         inhib_reg <= 2'h0;
      end else if (cnt_wr) begin
         inhib_reg <= INHIBIT_CYC;
      end else if (cyc_end && inhib_reg != 2'h0) begin
         inhib_reg <= inhib_reg - 2'h1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_reg <= CNT_RESET;
      end else if (cnt_wr) begin
         cnt_reg <= hwdata[7:0];
      end else if (cnt_step) begin
         cnt_reg <= cnt_reg + 8'h01;
      end
   end

   // ---------------- interrupt control and flag ----------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ictl_reg <= ICTL_RESET;
      end else begin
         if (ictl_wr) ictl_reg <= hwdata[7:0];
         if (clr_wr && hwdata[EV_OVF]) ictl_reg[OVF_BIT] <= 1'b0;
         // set wins over a same-cycle clear
         if (ovf_event) begin
            ictl_reg[OVF_BIT] <= 1'b1;
         end
      end
   end

   // both enables must be set; the flag itself stays visible regardless
   assign irq_req = ictl_reg[OVF_BIT] && ictl_reg[OVIE_BIT] && ien_reg[EV_OVF];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         timer_irq <= 1'b0;
      end else begin
         timer_irq <= irq_req;
      end
   end
endmodule // t8sp_timer

// ==== verification/t8sp_pin_model.sv ====
`timescale 1ns/100ps
module t8sp_pin_model (
   input  wire logic       hclk,
   input  wire logic       start,
   input  wire logic [3:0] nedge,
   input  wire logic [3:0] half,
   output logic            pin,
   output logic            busy
);
   initial begin
      pin = 1'b0;
      busy = 1'b0;
   end
   // each level is held half clocks; short levels stress the sampler
   always @(posedge hclk) begin
      if (start && !busy) begin
         busy <= 1'b1;
         for (int i = 0; i < nedge; i++) begin
            repeat (half) @(posedge hclk);
            pin <= ~pin;
         end
         repeat (half) @(posedge hclk);
         busy <= 1'b0;
      end
   end
endmodule // t8sp_pin_model

// ==== verification/t8sp_timer_checker.sv ====
`timescale 1ns/100ps
module t8sp_checker
   import t8sp_pkg::*;
#(
   parameter int PRE_W = 8
) (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic        timer_irq,
   input wire logic        watchdog_tick,
   input wire logic        watchdog_clear
);
   logic       wr_q;
   logic       rd_q;
   logic [7:0] addr_q;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_q   <= 1'b0;
         rd_q   <= 1'b0;
         addr_q <= 8'h00;
      end else if (hready) begin
         wr_q   <= hsel && htrans == HTRANS_NSEQ && hwrite;
         rd_q   <= hsel && htrans == HTRANS_NSEQ && !hwrite;
         addr_q <= haddr[7:0];
      end
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   a_ready_high: assert property (hreadyout) else $error("wait state seen");
   a_resp_okay: assert property (!hresp) else $error("error response seen");
   a_irq_masked: assert property (
      wr_q && addr_q == IEN_OFFS && !hwdata[EV_OVF] |-> ##2 !timer_irq [*2])
      else $error("irq stays up after mask");
   a_irq_reset: assert property ($rose(hresetn) |-> !timer_irq)
      else $error("irq up after reset");
   a_clear_watchdog_instr_echo: assert property (
      wr_q && addr_q == SYS_OFFS && hwdata[CLEAR_WATCHDOG_INSTR_BIT] |-> ##[1:3] watchdog_clear)
      else $error("no watchdog clear");
   a_clear_watchdog_instr_pulse: assert property (watchdog_clear |=> !watchdog_clear)
      else $error("clear not a pulse");
   a_tick_pulse: assert property (watchdog_tick |=> !watchdog_tick)
      else $error("tick not a pulse");
   a_rdata_hold: assert property (!rd_q |-> $stable(hrdata))
      else $error("read data moved");
   a_unmapped_zero: assert property (rd_q && addr_q == 8'h1C |-> hrdata == 32'h0000_0000)
      else $error("unmapped read not zero");
endmodule // t8sp_checker
bind t8sp_timer t8sp_checker #(.PRE_W(PRE_W)) u_chk (.hclk, .hresetn, .hsel, .haddr,
   .htrans, .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .timer_irq,
   .watchdog_tick, .watchdog_clear);

// ==== verification/test_timer8_shared_prescaler.sv ====
`timescale 1ns/100ps
module test_timer8_shared_prescaler;
   import t8sp_pkg::*;
   logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = {1'b0, HSIZE_WORD};
   logic        hreadyout, hresp, pin, irq, busy, start = 1'b0;
   logic [3:0]  nedge = 4'h0, half = 4'h0;
   logic [7:0]  a, b;
   int          num_errors = 0, tests_run = 0, cyc = 0;
   always #5 hclk = ~hclk;
   t8sp_timer dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hrdata, .hreadyout, .hresp, .counter_input_pin(pin),
      .timer_irq(irq), .watchdog_tick(), .watchdog_clear());
   t8sp_pin_model u_pin (.hclk, .start, .nedge, .half, .pin, .busy);
   task automatic bus(input logic [7:0] ad, input logic wr, input logic [7:0] d,
                      output logic [7:0] q);
      hsel   <= 1'b1;
      haddr  <= {24'h00_0000, ad};
      htrans <= HTRANS_NSEQ;
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h00_0000, d};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata[7:0];
   endtask
   task automatic w(input logic [7:0] ad, input logic [7:0] d);
      logic [7:0] t;
      bus(ad, 1'b1, d, t);
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge hclk);
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // counter mode frame: nine toggles from the current pin level
   task automatic frame(input logic [7:0] opt, input logic [3:0] h);
      w(CNT_OFFS, 8'h00);
      w(OPT_OFFS, opt);
      tick(12);
      nedge <= 4'h9;
      half  <= h;
      start <= 1'b1;
      tick(1);
      start <= 1'b0;
      tick(1);
      while (busy !== 1'b0) tick(1);
      tick(12);
      bus(CNT_OFFS, 1'b0, 8'h00, a);
      chk(a, 8'h04);
   endtask
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 20000) begin
         num_errors++;
         final_report;
      end
   end
   initial begin
      int p;
      tick(2);
      hresetn <= 1'b1;
      tick(1);
      bus(OPT_OFFS, 1'b0, 8'h00, a);
      chk(a, OPT_RESET);
      bus(CNT_OFFS, 1'b0, 8'h00, a);
      chk(a, CNT_RESET);
      bus(ICTL_OFFS, 1'b0, 8'h00, a);
      chk(a, ICTL_RESET);
      bus(8'h1C, 1'b0, 8'h00, a);
      chk(a, 8'h00);
      $display("reset values done");
      // code 8 stands for the prescaler handed to the watchdog
      for (int k = 0; k < 9; k++) begin
         p = (k == 8) ? 4 : 8 << k;
         w(SYS_OFFS, 8'h02);
         w(CNT_OFFS, 8'h00);
         w(OPT_OFFS, (k == 8) ? 8'h08 : 8'(k));
         w(SYS_OFFS, 8'h02);
         tick(16);
         bus(CNT_OFFS, 1'b0, 8'h00, a);
         tick(2 * p - 2);
         bus(CNT_OFFS, 1'b0, 8'h00, b);
         chk(b - a, 8'h02);
      end
      $display("rates done");
      w(CNT_OFFS, 8'h10);
      tick(5);
      bus(CNT_OFFS, 1'b0, 8'h00, a);
      chk(a, 8'h10);
      tick(8);
      bus(CNT_OFFS, 1'b0, 8'h00, b);
      chk({7'h00, b > 8'h10}, 8'h01);
      w(SYS_OFFS, 8'h01);
      tick(4);
      bus(CNT_OFFS, 1'b0, 8'h00, a);
      tick(38);
      bus(CNT_OFFS, 1'b0, 8'h00, b);
      chk(b, a);
      w(SYS_OFFS, 8'h00);
      $display("inhibit and sleep done");
      w(ICTL_OFFS, 8'h00);
      w(IEN_OFFS, 8'h01);
      w(CNT_OFFS, 8'hFE);
      tick(24);
      bus(STAT_OFFS, 1'b0, 8'h00, a);
      chk(a, 8'h01);
      chk({7'h00, irq}, 8'h00);
      w(ICTL_OFFS, 8'h24);
      tick(3);
      chk({7'h00, irq}, 8'h01);
      w(IEN_OFFS, 8'h00);
      tick(3);
      chk({7'h00, irq}, 8'h00);
      w(IEN_OFFS, 8'h01);
      tick(3);
      chk({7'h00, irq}, 8'h01);
      w(CLR_OFFS, 8'h01);
      tick(3);
      chk({7'h00, irq}, 8'h00);
      bus(STAT_OFFS, 1'b0, 8'h00, a);
      chk(a, 8'h00);
      $display("overflow done");
      frame(8'h38, 4'h8);
      frame(8'h28, 4'h4);
      $display("counter mode done");
      final_report;
   end
endmodule // test_timer8_shared_prescaler
